// file: hdl/rdp_pg_timer.sv
module rdp_pg_timer import rdp_pkg::*; #(
	parameter int STEP_CYCLES = RDP_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	rdp_tmr_if.tmr t
);
	localparam int PW = $clog2(STEP_CYCLES + 1);
	localparam logic [PW-1:0] PRESC_LAST = PW'(STEP_CYCLES - 1);

	logic [PW-1:0] presc_r; // cycles within one step
	logic [7:0] steps_r; // whole steps elapsed
	logic good_r; // delay expired
	logic [7:0] target; // steps for current code
	logic step_end; // last cycle of a step
	logic hit; // target reached

	assign target = rdp_delay_steps(t.code);
	assign step_end = presc_r == PRESC_LAST;
	assign hit = step_end && (steps_r == 8'(target - 8'h1));
	assign t.good = good_r;

	always_ff @(posedge clk) begin
		if (reset || !t.run) begin
			presc_r <= '0;
			steps_r <= 8'h0;
			good_r <= 1'b0;
		end else if (!good_r) begin
			presc_r <= step_end ? '0 : PW'(presc_r + 1'b1);
			steps_r <= step_end ? 8'(steps_r + 8'h1) : steps_r;
			good_r <= hit;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_drop;
		!t.run |=> !t.good;
	endproperty
	a_drop: assert property (p_drop) else $error("good held without regulation");

	property p_rise;
		$rose(t.good) |-> $past(t.run) && $past(steps_r) == 8'($past(target) - 8'h1);
	endproperty
	a_rise: assert property (p_rise) else $error("good rose at wrong count");
endmodule : rdp_pg_timer

// file: hdl/rdp_regs.sv
// Notes on behaviour
// - enabled rail forces its discharge field 00
// - field 00 none, 01/10/11 100/200/500 ohm
// - bank a at 40h, stepdown four..one
// - bank b at 41h, linear two..stepdown five
// - bank c at 42h, top two bits reserved
// - delay register 43h, three-bit code
// - delay starts once group in regulation
// - delay codes map to nominal times
// - delay accurate within ten percent
// - host-driven output ignores the delay code
// - output three: good, shifter or host
// - enable bit zero overrides control pins
module rdp_regs import rdp_pkg::*; #(
	parameter int STEP_CYCLES = RDP_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [RDP_RAILS-1:0] rail_enable_bit,
	input wire logic [RDP_RAILS-1:0] rail_pin_req,
	output logic [RDP_RAILS-1:0] rail_on,
	output logic [RDP_SEL_W-1:0] discharge_sel,
	output logic [RDP_RAILS-1:0] discharge_100,
	output logic [RDP_RAILS-1:0] discharge_200,
	output logic [RDP_RAILS-1:0] discharge_500,
	input wire logic group_in_regulation,
	input wire logic shift_level_pin,
	input rdp_out_mode_type out_mode,
	input wire logic host_level,
	input wire logic vtt_use,
	output logic general_output_three,
	output logic vtt_enable
);
	localparam int SW = RDP_RAILS + 2;
	// field vector after reset, so the decode starts aligned with it
	localparam logic [RDP_SEL_W-1:0] RST_SEL = {RDP_RST_BANK_C[5:0], RDP_RST_BANK_B,
		RDP_RST_BANK_A};

	// pin synchronisers
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic [RDP_RAILS-1:0] req_s; // synced control pin requests
	logic reg_s; // synced regulation level
	logic shift_s; // synced shifter input

	// register bank state
	logic [7:0] bank_a_r;
	logic [7:0] bank_b_r;
	logic [7:0] bank_c_r;
	logic [7:0] pg_r;
	logic [7:0] bank_a_nxt;
	logic [7:0] bank_b_nxt;
	logic [7:0] bank_c_nxt;
	logic [7:0] pg_nxt;
	logic [7:0] rdata_r;
	logic [RDP_SEL_W-1:0] on_mask; // two bits per enabled rail
	logic [RDP_SEL_W-1:0] sel_nxt;

	// decoded outputs
	logic [RDP_RAILS-1:0] r100_r;
	logic [RDP_RAILS-1:0] r200_r;
	logic [RDP_RAILS-1:0] r500_r;
	logic out3_r;
	logic out3_nxt;
	logic vtt_r;
	logic [RDP_RAILS-1:0] dec_ok; // decode agrees with stored field, per rail

	// address decode
	wire hit_a = reg_addr == RDP_OFS_BANK_A;
	wire hit_b = reg_addr == RDP_OFS_BANK_B;
	wire hit_c = reg_addr == RDP_OFS_BANK_C;
	wire hit_pg = reg_addr == RDP_OFS_PG;
	wire [7:0] rd_mux = hit_a ? bank_a_r : hit_b ? bank_b_r :
		hit_c ? bank_c_r : hit_pg ? pg_r : 8'h00;

	rdp_tmr_if tif();

	// two-flop pin capture
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {rail_pin_req, group_in_regulation, shift_level_pin};
			sync2_r <= sync1_r;
		end
	end
	assign req_s = sync2_r[SW-1:2];
	assign reg_s = sync2_r[1];
	assign shift_s = sync2_r[0];

	assign rail_on = rail_enable_bit & req_s;

	// per-rail mask and discharge decode
	genvar k;
	generate
		for (k = 0; k < RDP_RAILS; k++) begin : g_rail
			assign on_mask[2*k+1:2*k] = {2{rail_on[k]}};
			assign dec_ok[k] = discharge_100[k] == (discharge_sel[2*k+:2] == RDP_DIS_100)
				&& discharge_200[k] == (discharge_sel[2*k+:2] == RDP_DIS_200)
				&& discharge_500[k] == (discharge_sel[2*k+:2] == RDP_DIS_500);
			// resistance decode, reset value decoded from reset fields
			always_ff @(posedge clk) begin
				if (reset) begin
					r100_r[k] <= RST_SEL[2*k+:2] == RDP_DIS_100;
					r200_r[k] <= RST_SEL[2*k+:2] == RDP_DIS_200;
					r500_r[k] <= RST_SEL[2*k+:2] == RDP_DIS_500;
				end else begin
					r100_r[k] <= sel_nxt[2*k+1:2*k] == RDP_DIS_100;
					r200_r[k] <= sel_nxt[2*k+1:2*k] == RDP_DIS_200;
					r500_r[k] <= sel_nxt[2*k+1:2*k] == RDP_DIS_500;
				end
			end
		end
	endgenerate

	// bank a write; enabled rail clears
	assign bank_a_nxt = ((reg_wr && hit_a) ? reg_wdata : bank_a_r) & ~on_mask[7:0];
	// bank b write; enabled rail clears
	assign bank_b_nxt = ((reg_wr && hit_b) ? reg_wdata : bank_b_r) & ~on_mask[15:8];
	assign bank_c_nxt = ((reg_wr && hit_c) ? reg_wdata : bank_c_r) & RDP_MASK_BANK_C
		& ~{2'h0, on_mask[RDP_SEL_W-1:16]};
	assign pg_nxt = (reg_wr && hit_pg) ? (reg_wdata & RDP_MASK_PG) : pg_r;
	assign sel_nxt = {bank_c_nxt[5:0], bank_b_nxt, bank_a_nxt};

	// register storage and read capture
	always_ff @(posedge clk) begin
		if (reset) begin
			bank_a_r <= RDP_RST_BANK_A;
			bank_b_r <= RDP_RST_BANK_B;
			bank_c_r <= RDP_RST_BANK_C;
			pg_r <= RDP_RST_PG;
			rdata_r <= 8'h00;
		end else begin
			bank_a_r <= bank_a_nxt;
			bank_b_r <= bank_b_nxt;
			bank_c_r <= bank_c_nxt;
			pg_r <= pg_nxt;
			rdata_r <= reg_rd ? rd_mux : rdata_r;
		end
	end

	// timer idle when host-driven and no termination use
	assign tif.run = reg_s && (out_mode != RDP_OUT_HOST || vtt_use);
	assign tif.code = pg_r[2:0];

	rdp_pg_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
		.clk(clk),
		.reset(reset),
		.t(tif.tmr)
	);

	always_comb begin
		out3_nxt = 1'b0;
		unique case (out_mode)
			RDP_OUT_GOOD: out3_nxt = tif.good;
			RDP_OUT_SHIFT: out3_nxt = tif.good & shift_s;
			RDP_OUT_HOST: out3_nxt = host_level;
			default: out3_nxt = 1'b0;
		endcase
	end

	// output three and termination enable
	always_ff @(posedge clk) begin
		if (reset) begin
			out3_r <= 1'b0;
			vtt_r <= 1'b0;
		end else begin
			out3_r <= out3_nxt;
			vtt_r <= vtt_use & tif.good;
		end
	end

	assign reg_rdata = rdata_r;
	assign discharge_sel = {bank_c_r[5:0], bank_b_r, bank_a_r};
	assign discharge_100 = r100_r;
	assign discharge_200 = r200_r;
	assign discharge_500 = r500_r;
	assign general_output_three = out3_r;
	assign vtt_enable = vtt_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_clear;
		$past(on_mask) != '0 |-> (discharge_sel & $past(on_mask)) == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("enabled rail kept discharge");

	property p_decode;
		dec_ok == '1;
	endproperty
	a_decode: assert property (p_decode) else $error("discharge decode mismatch");

	sequence s_wr_a;
		reg_wr && hit_a && rail_on == '0;
	endsequence
	sequence s_rd_a;
		reg_rd && hit_a && !reg_wr && rail_on == '0;
	endsequence
	sequence s_gap_a;
		!(reg_wr && hit_a) && rail_on == '0;
	endsequence
	property p_bank_a;
		s_wr_a ##1 s_gap_a ##1 s_rd_a |=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_bank_a: assert property (p_bank_a) else $error("bank a readback wrong");

	sequence s_wr_b;
		reg_wr && hit_b && rail_on == '0;
	endsequence
	sequence s_rd_b;
		reg_rd && hit_b && !reg_wr && rail_on == '0;
	endsequence
	sequence s_gap_b;
		!(reg_wr && hit_b) && rail_on == '0;
	endsequence
	property p_bank_b;
		s_wr_b ##1 s_gap_b ##1 s_rd_b |=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_bank_b: assert property (p_bank_b) else $error("bank b readback wrong");

	property p_bank_c;
		reg_rd && hit_c |=> reg_rdata[7:6] == 2'h0;
	endproperty
	a_bank_c: assert property (p_bank_c) else $error("bank c reserved bits set");

	sequence s_wr_pg;
		reg_wr && hit_pg;
	endsequence
	sequence s_rd_pg;
		reg_rd && hit_pg && !reg_wr;
	endsequence
	property p_pg_reg;
		s_wr_pg ##1 !(reg_wr && hit_pg) ##1 s_rd_pg
			|=> reg_rdata == ($past(reg_wdata, 3) & RDP_MASK_PG);
	endproperty
	a_pg_reg: assert property (p_pg_reg) else $error("delay register readback wrong");

	property p_host;
		out_mode == RDP_OUT_HOST |=> general_output_three == $past(host_level);
	endproperty
	a_host: assert property (p_host) else $error("host level not followed");

	property p_good_out;
		out_mode == RDP_OUT_GOOD |=> general_output_three == $past(tif.good);
	endproperty
	a_good_out: assert property (p_good_out) else $error("good not routed");

	// pins reach rail_on through two flops once out of reset
	property p_enable;
		!$past(reset) && !$past(reset, 2)
			|-> rail_on == (rail_enable_bit & $past(rail_pin_req, 2));
	endproperty
	a_enable: assert property (p_enable) else $error("rail on while bit zero");
endmodule : rdp_regs

// file: inc/rdp_pkg.sv
package rdp_pkg;
	// register offsets
	localparam logic [7:0] RDP_OFS_BANK_A = 8'h40;
	localparam logic [7:0] RDP_OFS_BANK_B = 8'h41;
	localparam logic [7:0] RDP_OFS_BANK_C = 8'h42;
	localparam logic [7:0] RDP_OFS_PG = 8'h43;
	// values after reset
	localparam logic [7:0] RDP_RST_BANK_A = 8'h55;
	localparam logic [7:0] RDP_RST_BANK_B = 8'h45;
	localparam logic [7:0] RDP_RST_BANK_C = 8'h01;
	localparam logic [7:0] RDP_RST_PG = 8'h00;
	// writable bits; the rest read as zero
	localparam logic [7:0] RDP_MASK_BANK_C = 8'h3f;
	localparam logic [7:0] RDP_MASK_PG = 8'h07;
	// rail count and flat field vector width
	localparam int RDP_RAILS = 11;
	localparam int RDP_SEL_W = 2 * RDP_RAILS;
	// discharge field codes
	localparam logic [1:0] RDP_DIS_NONE = 2'h0;
	localparam logic [1:0] RDP_DIS_100 = 2'h1;
	localparam logic [1:0] RDP_DIS_200 = 2'h2;
	localparam logic [1:0] RDP_DIS_500 = 2'h3;
	// clock and delay step timing
	localparam int RDP_CLK_MHZ = 250;
	localparam int RDP_STEP_US = 500;
	localparam int RDP_STEP_CYCLES = RDP_CLK_MHZ * RDP_STEP_US;
	// nominal delays in microseconds
	localparam int RDP_DLY_000_US = 2500;
	localparam int RDP_DLY_001_US = 5000;
	localparam int RDP_DLY_010_US = 10000;
	localparam int RDP_DLY_011_US = 15000;
	localparam int RDP_DLY_100_US = 20000;
	localparam int RDP_DLY_101_US = 50000;
	localparam int RDP_DLY_11X_US = 100000;
	// output three usage
	typedef enum logic [1:0] {RDP_OUT_GOOD, RDP_OUT_SHIFT, RDP_OUT_HOST} rdp_out_mode_type;

	// delay code to count of steps
	function automatic logic [7:0] rdp_delay_steps(input logic [2:0] code);
		int us;
		us = RDP_DLY_11X_US;
		case (code)
			3'h0: us = RDP_DLY_000_US;
			3'h1: us = RDP_DLY_001_US;
			3'h2: us = RDP_DLY_010_US;
			3'h3: us = RDP_DLY_011_US;
			3'h4: us = RDP_DLY_100_US;
			3'h5: us = RDP_DLY_101_US;
			default: us = RDP_DLY_11X_US;
		endcase
		return 8'(us / RDP_STEP_US);
	endfunction : rdp_delay_steps
endpackage : rdp_pkg

// file: inc/rdp_tmr_if.sv
// carrier between register bank and power-good timer
interface rdp_tmr_if;
	logic run; // group in regulation and delay in use
	logic [2:0] code; // delay code
	logic good; // delay expired
	modport ctl(output run, output code, input good);
	modport tmr(input run, input code, output good);
endinterface : rdp_tmr_if

// file: test/rdp_host_model.sv
// register-port master standing in for the serial engine
module rdp_host_model (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle port at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// one byte, strobe held for exactly one taken edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= wr;
		reg_rd <= ~wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// released lines never keep the last value
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : xfer
endmodule : rdp_host_model

// file: test/rdp_regs_tb.sv
module rdp_regs_tb import rdp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 4; // shortened delay step
	logic clk, reset, reg_wr, reg_rd;
	logic rd_d = 1'b0; // read strobe taken at the last edge
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [RDP_RAILS-1:0] en, pin, rail_on, d100, d200, d500;
	logic [RDP_SEL_W-1:0] dsel;
	logic greg, shift, host_level, vtt_use, out3, vtt_en;
	rdp_out_mode_type mode;
	int miscompares, n_checks;
	int seed = 32'hf6fb;
	logic [7:0] exp_q[$]; // expected read bytes, oldest first

	rdp_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata));
	rdp_regs #(.STEP_CYCLES(STEP)) DUT (.clk(clk), .reset(reset), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.rail_enable_bit(en), .rail_pin_req(pin), .rail_on(rail_on), .discharge_sel(dsel),
		.discharge_100(d100), .discharge_200(d200), .discharge_500(d500),
		.group_in_regulation(greg), .shift_level_pin(shift), .out_mode(mode),
		.host_level(host_level), .vtt_use(vtt_use), .general_output_three(out3),
		.vtt_enable(vtt_en));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// read with the expected byte noted first
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.xfer(1'b0, a, 8'h00);
	endtask : rd

	// read data lands one edge after the taken strobe
	always @(posedge clk) begin
		if (rd_d) check(reg_rdata, exp_q.pop_front());
		rd_d <= reg_rd;
	end

	// hang guard
	initial begin
		#100000;
		miscompares++;
		finish_test;
	end

	// main sequence
	initial begin
		logic [RDP_SEL_W-1:0] w, ex;
		int n;
		int us[8];
		reset = 1'b1;
		en = '0;
		pin = '0;
		greg = 1'b0;
		shift = 1'b0;
		mode = RDP_OUT_GOOD;
		host_level = 1'b0;
		vtt_use = 1'b0;
		miscompares = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		// reset values, unmapped place, reserved bits
		rd(RDP_OFS_BANK_A, 8'h55);
		rd(RDP_OFS_BANK_B, 8'h45);
		rd(RDP_OFS_BANK_C, 8'h01);
		rd(RDP_OFS_PG, 8'h00);
		rd(8'h44, 8'h00);
		host.xfer(1'b1, RDP_OFS_BANK_C, 8'hff);
		rd(RDP_OFS_BANK_C, 8'h3f);
		// full-width write and readback of banks a and b
		host.xfer(1'b1, RDP_OFS_BANK_A, 8'h9c);
		rd(RDP_OFS_BANK_A, 8'h9c);
		host.xfer(1'b1, RDP_OFS_BANK_B, 8'h36);
		rd(RDP_OFS_BANK_B, 8'h36);
		$display("test reset_and_reserved done");
		// random data, random enables: enabled fields forced to none
		for (int i = 0; i < 12; i++) begin
			en <= i < 4 ? '0 : RDP_RAILS'($random(seed));
			pin <= RDP_RAILS'($random(seed));
			repeat (3) @(posedge clk);
			w = RDP_SEL_W'($random(seed));
			host.xfer(1'b1, RDP_OFS_BANK_A, w[7:0]);
			host.xfer(1'b1, RDP_OFS_BANK_B, w[15:8]);
			host.xfer(1'b1, RDP_OFS_BANK_C, {2'h3, w[21:16]});
			@(posedge clk);
			check(rail_on, en & pin);
			ex = w;
			for (int k = 0; k < RDP_RAILS; k++) begin
				if (en[k] & pin[k]) ex[2*k +: 2] = 2'h0;
				check({d500[k], d200[k], d100[k]}, 3'((4'h1 << ex[2*k +: 2]) >> 1));
			end
			check(dsel, ex);
			rd(RDP_OFS_BANK_A, ex[7:0]);
			rd(RDP_OFS_BANK_B, ex[15:8]);
			rd(RDP_OFS_BANK_C, {2'h0, ex[21:16]});
		end
		en <= '0;
		$display("test discharge done");
		// every delay code, then shifter and termination uses
		us = '{2500, 5000, 10000, 15000, 20000, 50000, 100000, 100000};
		for (int c = 0; c < 10; c++) begin
			mode <= c == 8 ? RDP_OUT_SHIFT : c == 9 ? RDP_OUT_HOST : RDP_OUT_GOOD;
			vtt_use <= c == 9;
			shift <= 1'b1;
			host.xfer(1'b1, RDP_OFS_PG, 8'(c % 8) | 8'hf8);
			rd(RDP_OFS_PG, 8'(c % 8));
			greg <= 1'b1;
			n = 0;
			while (!(out3 | vtt_en) && n < 1000) begin
				@(posedge clk);
				n++;
			end
			// nominal count plus sync latency, ten percent either way
			n = n * 10 - us[c % 8] / 500 * STEP * 10;
			check(n >= -us[c % 8] / 500 * STEP && n <= us[c % 8] / 500 * STEP + 60, 1'b1);
			// shifter output follows its input while good
			if (c == 8) begin
				shift <= 1'b0;
				repeat (4) @(posedge clk);
				check(out3, 1'b0);
			end
			greg <= 1'b0;
			repeat (6) @(posedge clk);
			check(out3 | vtt_en, 1'b0);
		end
		$display("test delay done");
		// host-driven output ignores regulation and delay
		mode <= RDP_OUT_HOST;
		vtt_use <= 1'b0;
		host_level <= 1'b1;
		repeat (3) @(posedge clk);
		check(out3, 1'b1);
		host_level <= 1'b0;
		greg <= 1'b1;
		repeat (60) @(posedge clk);
		check(out3 | vtt_en, 1'b0);
		// leaving host use must start the delay afresh
		mode <= RDP_OUT_GOOD;
		repeat (3) @(posedge clk);
		check(out3, 1'b0);
		repeat (45) @(posedge clk);
		check(out3, 1'b1);
		$display("test host_output done");
		repeat (3) @(posedge clk);
		finish_test;
	end
endmodule : rdp_regs_tb
